// ---- hw/pdg_cfg.svh ----
`ifndef PDG_CFG_SVH
`define PDG_CFG_SVH
// Purpose: offsets, reset values and widths of the deviation guard
// Assumes: 32-bit register port, word index addressing
// Notes:   definitions only
`define PDG_AW              4
`define PDG_DW              32
`define PDG_LVL_W           30
`define PDG_PCT_W           7
`define PDG_SPD_W           14
`define PDG_POS_W           32
`define PDG_TRQ_W           16
`define PDG_VIB_W           16
`define PDG_EVT_W           8
// register indices
`define PDG_OFS_CTRL        4'h0
`define PDG_OFS_ALM_LVL     4'h1
`define PDG_OFS_WRN_PCT     4'h2
`define PDG_OFS_SON_LVL     4'h3
`define PDG_OFS_SON_PCT     4'h4
`define PDG_OFS_SON_SPD     4'h5
`define PDG_OFS_VIB_LVL     4'h6
`define PDG_OFS_TRQ_LIM     4'h7
`define PDG_OFS_STATUS      4'h8
`define PDG_OFS_MASK        4'h9
`define PDG_OFS_DEV         4'hA
`define PDG_OFS_LIVE        4'hB
// reset values and limits
`define PDG_LVL_MIN         30'h0000_0001
`define PDG_LVL_DEF         30'h0050_0000
`define PDG_PCT_MIN         7'h0A
`define PDG_PCT_MAX         7'h64
`define PDG_PCT_DEF         7'h64
`define PDG_SPD_MAX         14'h2710
`define PDG_SPD_DEF         14'h2710
`define PDG_VIB_DEF         16'h0100
`define PDG_TRQ_DEF         16'h7FFF
// ctrl field positions
`define PDG_CTRL_SON_B      0
`define PDG_CTRL_MODE_LSB   1
`define PDG_CTRL_RST_B      3
// event bit positions
`define PDG_EV_OVF_ALM      0
`define PDG_EV_OVF_WRN      1
`define PDG_EV_SON_ALM      2
`define PDG_EV_SON_WRN      3
`define PDG_EV_SPD_ALM      4
`define PDG_EV_VIB_ALM      5
`define PDG_EV_VIB_WRN      6
`define PDG_EV_OT           7
`endif

// ---- hw/pdg_pkg.sv ----
// Purpose: types for the position deviation guard
// Assumes: pdg_cfg.svh widths
// Notes:   none
`include "pdg_cfg.svh"
package pdg_pkg;
    typedef enum logic [1:0] {
        PDG_MODE_POS,
        PDG_MODE_SPD,
        PDG_MODE_TRQ,
        PDG_MODE_RSV
    } pdg_mode_e;
    typedef enum logic [1:0] {
        PDG_ST_OFF,
        PDG_ST_LIMIT,
        PDG_ST_RUN,
        PDG_ST_STOP
    } pdg_state_e;
    typedef struct packed {
        logic [`PDG_LVL_W-1:0] alm;
        logic [`PDG_PCT_W-1:0] pct;
    } pdg_thr_s;
    typedef struct packed {
        logic alm;
        logic wrn;
    } pdg_cmp_s;
endpackage : pdg_pkg

// ---- hw/pdg_thresh.sv ----
// Purpose: magnitude compare of deviation against alarm and warning level
// Assumes: pct within 10..100, level within 1..2^30-1
// Notes:   combinational; used for normal and servo-on level pairs
`include "pdg_cfg.svh"
module pdg_thresh
    import pdg_pkg::*;
(
    // operands
    input  wire logic [`PDG_POS_W:0]   mag_i,
    input  wire pdg_thr_s              thr_i,
    // result
    output pdg_cmp_s                   cmp_o
);
    localparam int PW = `PDG_LVL_W + `PDG_PCT_W;
    wire logic [PW-1:0]          prod;
    wire logic [PW-1:0]          wrn_lvl;
    wire logic [PW-1:0]          mag_x;
    assign prod    = PW'(thr_i.alm) * PW'(thr_i.pct);
    assign wrn_lvl = prod / PW'(`PDG_PCT_MAX);
    assign mag_x   = PW'(mag_i);
    assign cmp_o.alm = mag_x > PW'(thr_i.alm);
    assign cmp_o.wrn = mag_x > wrn_lvl;
endmodule : pdg_thresh

// ---- hw/pdg_regs.sv ----
// Purpose: sticky event status, clear on read, and masked interrupt
// Assumes: events are one-cycle or level; set wins over read clear
// Notes:   irq registered
`include "pdg_cfg.svh"
module pdg_regs
    import pdg_pkg::*;
(
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    arst_n_i,
    // events and control
    input  wire logic [`PDG_EVT_W-1:0]   evt_i,
    input  wire logic                    clr_i,
    input  wire logic [`PDG_EVT_W-1:0]   mask_i,
    // state
    output logic      [`PDG_EVT_W-1:0]   status_o,
    output logic                         irq_o
);
    wire logic [`PDG_EVT_W-1:0]  status_next;
    assign status_next = (clr_i ? '0 : status_o) | evt_i;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_o <= '0;
            irq_o    <= 1'b0;
        end else begin
            status_o <= status_next;
            irq_o    <= |(status_next & mask_i);
        end
    end
endmodule : pdg_regs

// ---- hw/pdg_guard.sv ----
// Purpose: position deviation guard for a servo position loop
// Assumes: position words are signed reference units from same clock
// Notes:   limit switch and servo-on come from pins and are synchronised
//
// Contract
// - overflow check only in position control
// - deviation is reference minus actual position
// - alarm when deviation exceeds alarm level
// - stop motor on excessive deviation
// - alarm level 1..1073741823, default 5242880, immediate
// - warning above level times percent over 100
// - warning percent 10..100, default 100, immediate
// - servo-on alarm if deviation exceeded while off
// - limit speed after servo-on with deviation left
// - reference during limit over alarm level alarms
// - servo-on percent 10..100; servo-on level like normal
// - servo-on warning at turn-on over scaled level
// - vibration level sets vibration alarm and warning
// - limit switch forces motor stop
// - clamp torque to configured limit
`include "pdg_cfg.svh"
module pdg_guard
    import pdg_pkg::*;
(
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          arst_n_i,
    // register port
    input  wire logic [`PDG_AW-1:0]            reg_addr_i,
    input  wire logic [`PDG_DW-1:0]            reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    output logic      [`PDG_DW-1:0]            reg_rdata_o,
    // position loop
    input  wire logic signed [`PDG_POS_W-1:0]  ref_pos_i,
    input  wire logic                          ref_valid_i,
    input  wire logic signed [`PDG_POS_W-1:0]  act_pos_i,
    input  wire logic [`PDG_VIB_W-1:0]         vib_i,
    input  wire logic signed [`PDG_TRQ_W-1:0]  trq_ref_i,
    // pins
    input  wire logic                          servo_on_pin_i,
    input  wire logic                          limit_sw_pin_i,
    // drive outputs
    output logic                               motor_stop_o,
    output logic                               speed_limit_en_o,
    output logic      [`PDG_SPD_W-1:0]         speed_limit_o,
    output logic signed [`PDG_TRQ_W-1:0]       trq_cmd_o,
    output logic                               alarm_o,
    output logic                               warning_o,
    output logic                               irq_o
);
////////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [1:0]                  mode_reg;
    logic [`PDG_LVL_W-1:0]       alm_lvl_reg;
    logic [`PDG_PCT_W-1:0]       wrn_pct_reg;
    logic [`PDG_LVL_W-1:0]       son_lvl_reg;
    logic [`PDG_PCT_W-1:0]       son_pct_reg;
    logic [`PDG_SPD_W-1:0]       son_spd_reg;
    logic [`PDG_VIB_W-1:0]       vib_lvl_reg;
    logic [`PDG_TRQ_W-1:0]       trq_lim_reg;
    logic [`PDG_EVT_W-1:0]       mask_reg;
    logic [`PDG_DW-1:0]          rdata_reg;
    // pin synchronisers
    logic [1:0]                  son_sync_reg;
    logic [1:0]                  lim_sync_reg;
    logic                        son_d_reg;
    // guard state
    pdg_state_e                  state_reg;
    pdg_state_e                  state_next;
    logic                        off_exc_reg;
    logic signed [`PDG_POS_W:0]  dev_reg;
    logic [`PDG_EVT_W-1:0]       status;
    logic                        status_irq;
////////////////////////////////////////////////////////////////////////////
    // write decode and value clamps
    wire logic                   wr_ctrl;
    wire logic                   wr_alm;
    wire logic                   wr_wpct;
    wire logic                   wr_son;
    wire logic                   wr_spct;
    wire logic                   wr_spd;
    wire logic                   wr_vib;
    wire logic                   wr_trq;
    wire logic                   wr_mask;
    wire logic                   rd_stat;
    wire logic                   alarm_rst;
    wire logic [`PDG_LVL_W-1:0]  wr_lvl;
    wire logic [`PDG_PCT_W-1:0]  wr_pct;
    wire logic [`PDG_SPD_W-1:0]  wr_spdv;
    assign wr_ctrl = reg_wr_i && reg_addr_i == `PDG_OFS_CTRL;
    assign wr_alm  = reg_wr_i && reg_addr_i == `PDG_OFS_ALM_LVL;
    assign wr_wpct = reg_wr_i && reg_addr_i == `PDG_OFS_WRN_PCT;
    assign wr_son  = reg_wr_i && reg_addr_i == `PDG_OFS_SON_LVL;
    assign wr_spct = reg_wr_i && reg_addr_i == `PDG_OFS_SON_PCT;
    assign wr_spd  = reg_wr_i && reg_addr_i == `PDG_OFS_SON_SPD;
    assign wr_vib  = reg_wr_i && reg_addr_i == `PDG_OFS_VIB_LVL;
    assign wr_trq  = reg_wr_i && reg_addr_i == `PDG_OFS_TRQ_LIM;
    assign wr_mask = reg_wr_i && reg_addr_i == `PDG_OFS_MASK;
    assign rd_stat = reg_rd_i && reg_addr_i == `PDG_OFS_STATUS;
    assign alarm_rst = wr_ctrl && reg_wdata_i[`PDG_CTRL_RST_B];
    // percent and speed writes saturate to the nearest legal value; a level write keeps bits 29:0, with 0 becoming 1
    assign wr_lvl = (reg_wdata_i[`PDG_LVL_W-1:0] == '0) ? `PDG_LVL_MIN
                    : reg_wdata_i[`PDG_LVL_W-1:0];
    assign wr_pct = (reg_wdata_i[`PDG_DW-1:0] < 32'h0000_000A)
                    ? `PDG_PCT_MIN
                    : (reg_wdata_i[`PDG_DW-1:0] > 32'h0000_0064)
                    ? `PDG_PCT_MAX
                    : reg_wdata_i[`PDG_PCT_W-1:0];
    assign wr_spdv = (reg_wdata_i[`PDG_DW-1:0] > 32'h0000_2710)
                     ? `PDG_SPD_MAX
                     : reg_wdata_i[`PDG_SPD_W-1:0];
////////////////////////////////////////////////////////////////////////////
    // configuration writes take effect on the next cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_reg    <= 2'h0;
            alm_lvl_reg <= `PDG_LVL_DEF;
            wrn_pct_reg <= `PDG_PCT_DEF;
            son_lvl_reg <= `PDG_LVL_DEF;
            son_pct_reg <= `PDG_PCT_DEF;
            son_spd_reg <= `PDG_SPD_DEF;
            vib_lvl_reg <= `PDG_VIB_DEF;
            trq_lim_reg <= `PDG_TRQ_DEF;
            mask_reg    <= '0;
        end else begin
            if (wr_ctrl)
                mode_reg <= reg_wdata_i[`PDG_CTRL_MODE_LSB+:2];
            if (wr_alm)  alm_lvl_reg <= wr_lvl;
            if (wr_wpct) wrn_pct_reg <= wr_pct;
            if (wr_son)  son_lvl_reg <= wr_lvl;
            if (wr_spct) son_pct_reg <= wr_pct;
            if (wr_spd)  son_spd_reg <= wr_spdv;
            if (wr_vib)  vib_lvl_reg <= reg_wdata_i[`PDG_VIB_W-1:0];
            if (wr_trq)  trq_lim_reg <= {1'b0, reg_wdata_i[`PDG_TRQ_W-2:0]};
            if (wr_mask) mask_reg <= reg_wdata_i[`PDG_EVT_W-1:0];
        end
    end
////////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers for the pins
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            son_sync_reg <= 2'b00;
            lim_sync_reg <= 2'b00;
            son_d_reg    <= 1'b0;
        end else begin
            son_sync_reg <= {son_sync_reg[0], servo_on_pin_i};
            lim_sync_reg <= {lim_sync_reg[0], limit_sw_pin_i};
            son_d_reg    <= son_sync_reg[1];
        end
    end
    wire logic                   servo_on;
    wire logic                   son_rise;
    wire logic                   limit_hit;
    assign servo_on  = son_sync_reg[1];
    assign son_rise  = servo_on && !son_d_reg;
    assign limit_hit = lim_sync_reg[1];
////////////////////////////////////////////////////////////////////////////
    // deviation and its magnitude
    wire logic signed [`PDG_POS_W:0] dev_now;
    wire logic [`PDG_POS_W:0]        dev_mag;
    assign dev_now = {ref_pos_i[`PDG_POS_W-1], ref_pos_i}
                   - {act_pos_i[`PDG_POS_W-1], act_pos_i};
    assign dev_mag = dev_now[`PDG_POS_W] ? -dev_now : dev_now;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            dev_reg <= '0;
        else
            dev_reg <= dev_now;
    end
    pdg_cmp_s                    cmp_norm;
    pdg_cmp_s                    cmp_son;
    pdg_thresh u_thr_norm (
        .mag_i (dev_mag),
        .thr_i ('{alm: alm_lvl_reg, pct: wrn_pct_reg}),
        .cmp_o (cmp_norm)
    );
    pdg_thresh u_thr_son (
        .mag_i (dev_mag),
        .thr_i ('{alm: son_lvl_reg, pct: son_pct_reg}),
        .cmp_o (cmp_son)
    );
////////////////////////////////////////////////////////////////////////////
    // event detection
    wire logic                   pos_mode;
    wire logic                   running;
    wire logic                   dev_left;
    wire logic [`PDG_EVT_W-1:0]  evt;
    assign pos_mode = mode_reg == 2'(PDG_MODE_POS);
    assign running  = state_reg == PDG_ST_RUN
                    || state_reg == PDG_ST_LIMIT;
    assign dev_left = dev_mag != '0;
    assign evt[`PDG_EV_OVF_ALM] = pos_mode && running
                                && cmp_norm.alm;
    assign evt[`PDG_EV_OVF_WRN] = pos_mode && running
                                && cmp_norm.wrn;
    assign evt[`PDG_EV_SON_ALM] = pos_mode && son_rise
                                && off_exc_reg;
    assign evt[`PDG_EV_SON_WRN] = pos_mode && son_rise
                                && cmp_son.wrn;
    assign evt[`PDG_EV_SPD_ALM] = pos_mode
                                && state_reg == PDG_ST_LIMIT
                                && ref_valid_i && cmp_norm.alm;
    assign evt[`PDG_EV_VIB_ALM] = running && vib_i > vib_lvl_reg;
    assign evt[`PDG_EV_VIB_WRN] = running
                                && vib_i > (vib_lvl_reg >> 1);
    assign evt[`PDG_EV_OT]      = limit_hit;
    wire logic                   stop_evt;
    assign stop_evt = evt[`PDG_EV_OVF_ALM] || evt[`PDG_EV_SON_ALM]
                    || evt[`PDG_EV_SPD_ALM] || evt[`PDG_EV_VIB_ALM];
////////////////////////////////////////////////////////////////////////////
    // servo sequencing: off, speed limited, running, stopped by alarm
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PDG_ST_OFF:
                if (stop_evt)
                    state_next = PDG_ST_STOP;
                else if (son_rise)
                    state_next = dev_left && pos_mode ? PDG_ST_LIMIT
                                                      : PDG_ST_RUN;
            PDG_ST_LIMIT:
                if (stop_evt)
                    state_next = PDG_ST_STOP;
                else if (!servo_on)
                    state_next = PDG_ST_OFF;
                else if (!dev_left)
                    state_next = PDG_ST_RUN;
            PDG_ST_RUN:
                if (stop_evt)
                    state_next = PDG_ST_STOP;
                else if (!servo_on)
                    state_next = PDG_ST_OFF;
            PDG_ST_STOP:
                if (alarm_rst && !servo_on)
                    state_next = PDG_ST_OFF;
        endcase
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg   <= PDG_ST_OFF;
            off_exc_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            // remembers an excess seen while the servo was off
            if (state_reg == PDG_ST_OFF && cmp_son.alm)
                off_exc_reg <= 1'b1;
            else if (state_reg != PDG_ST_OFF || alarm_rst)
                off_exc_reg <= 1'b0;
        end
    end
////////////////////////////////////////////////////////////////////////////
    // torque clamp
    wire logic signed [`PDG_TRQ_W-1:0] trq_lim;
    wire logic signed [`PDG_TRQ_W-1:0] trq_clamped;
    assign trq_lim = $signed(trq_lim_reg);
    assign trq_clamped = trq_ref_i > trq_lim ? trq_lim
                       : trq_ref_i < -trq_lim ? -trq_lim
                       : trq_ref_i;
    wire logic                   stop_now;
    assign stop_now = state_next == PDG_ST_STOP || limit_hit
                    || state_next == PDG_ST_OFF;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            motor_stop_o     <= 1'b1;
            speed_limit_en_o <= 1'b0;
            speed_limit_o    <= `PDG_SPD_DEF;
            trq_cmd_o        <= '0;
            alarm_o          <= 1'b0;
            warning_o        <= 1'b0;
        end else begin
            motor_stop_o     <= stop_now;
            speed_limit_en_o <= state_next == PDG_ST_LIMIT;
            speed_limit_o    <= son_spd_reg;
            trq_cmd_o        <= stop_now ? '0 : trq_clamped;
            alarm_o          <= state_next == PDG_ST_STOP;
            warning_o        <= evt[`PDG_EV_OVF_WRN] || evt[`PDG_EV_SON_WRN]
                              || evt[`PDG_EV_VIB_WRN];
        end
    end
////////////////////////////////////////////////////////////////////////////
    // status, mask, interrupt
    pdg_regs u_regs (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .evt_i    (evt),
        .clr_i    (rd_stat),
        .mask_i   (mask_reg),
        .status_o (status),
        .irq_o    (status_irq)
    );
    assign irq_o = status_irq;
    // read mux
    logic [`PDG_DW-1:0]          rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (reg_addr_i)
            `PDG_OFS_CTRL:    rd_mux = 32'({mode_reg, servo_on});
            `PDG_OFS_ALM_LVL: rd_mux = 32'(alm_lvl_reg);
            `PDG_OFS_WRN_PCT: rd_mux = 32'(wrn_pct_reg);
            `PDG_OFS_SON_LVL: rd_mux = 32'(son_lvl_reg);
            `PDG_OFS_SON_PCT: rd_mux = 32'(son_pct_reg);
            `PDG_OFS_SON_SPD: rd_mux = 32'(son_spd_reg);
            `PDG_OFS_VIB_LVL: rd_mux = 32'(vib_lvl_reg);
            `PDG_OFS_TRQ_LIM: rd_mux = 32'(trq_lim_reg);
            `PDG_OFS_STATUS:  rd_mux = 32'(status);
            `PDG_OFS_MASK:    rd_mux = 32'(mask_reg);
            `PDG_OFS_DEV:     rd_mux = dev_reg[`PDG_POS_W-1:0];
            `PDG_OFS_LIVE:    rd_mux = 32'({limit_hit, state_reg});
            default:          rd_mux = '0;
        endcase
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            rdata_reg <= '0;
        else
            rdata_reg <= reg_rd_i ? rd_mux : '0;
    end
    assign reg_rdata_o = rdata_reg;
endmodule : pdg_guard

// ---- dv/pdg_props.sv ----
// Purpose: port checker for the deviation guard
// Assumes: alarm level and mode followed from register writes
// Notes:   bound to pdg_guard
`include "pdg_cfg.svh"
module pdg_props (
    // clock, reset and register port
    input wire logic                         clk_i,
    input wire logic                         arst_n_i,
    input wire logic [`PDG_AW-1:0]           reg_addr_i,
    input wire logic [`PDG_DW-1:0]           reg_wdata_i,
    input wire logic                         reg_wr_i,
    input wire logic                         reg_rd_i,
    input wire logic [`PDG_DW-1:0]           reg_rdata_o,
    // loop inputs and pins
    input wire logic signed [`PDG_POS_W-1:0] ref_pos_i,
    input wire logic signed [`PDG_POS_W-1:0] act_pos_i,
    input wire logic                         servo_on_pin_i,
    input wire logic                         limit_sw_pin_i,
    // drive outputs
    input wire logic                         motor_stop_o,
    input wire logic                         speed_limit_en_o,
    input wire logic signed [`PDG_TRQ_W-1:0] trq_cmd_o,
    input wire logic                         alarm_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [`PDG_LVL_W-1:0] lvl_reg;
    logic [1:0]            mode_reg;
    logic                  rst_wr;
    logic [`PDG_POS_W:0]   dev;
    logic [`PDG_POS_W:0]   mag;
    logic                  over;
    assign rst_wr = reg_wr_i && reg_addr_i == `PDG_OFS_CTRL
                    && reg_wdata_i[`PDG_CTRL_RST_B];
    assign dev = {ref_pos_i[31], ref_pos_i} - {act_pos_i[31], act_pos_i};
    assign mag = dev[32] ? -dev : dev;
    assign over = mag > {3'h0, lvl_reg};
    // shadow of alarm level and control mode
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lvl_reg  <= `PDG_LVL_DEF;
            mode_reg <= 2'h0;
        end else if (reg_wr_i && reg_addr_i == `PDG_OFS_ALM_LVL) begin
            lvl_reg  <= reg_wdata_i[29:0] == 30'h0 ? `PDG_LVL_MIN
                        : reg_wdata_i[29:0];
        end else if (reg_wr_i && reg_addr_i == `PDG_OFS_CTRL) begin
            mode_reg <= reg_wdata_i[2:1];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    property p_rd_idle;
        !reg_rd_i |=> reg_rdata_o == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_alm_stop;
        alarm_o |-> motor_stop_o;
    endproperty
    a_alm_stop: assert property (p_alm_stop)
        else $error("alarm without stop");
    property p_alm_hold;
        $fell(alarm_o) |-> $past(rst_wr) || $past(rst_wr, 2);
    endproperty
    a_alm_hold: assert property (p_alm_hold)
        else $error("alarm left without reset");
    property p_trq_zero;
        motor_stop_o && $past(motor_stop_o) |-> trq_cmd_o == '0;
    endproperty
    a_trq_zero: assert property (p_trq_zero)
        else $error("torque while stopped");
    property p_ot_stop;
        limit_sw_pin_i [*5] |-> motor_stop_o;
    endproperty
    a_ot_stop: assert property (p_ot_stop)
        else $error("no stop on overtravel");
    property p_lim_start;
        $rose(speed_limit_en_o) |-> $past(servo_on_pin_i, 2);
    endproperty
    a_lim_start: assert property (p_lim_start)
        else $error("speed limit without servo on");
    property p_lim_stop;
        motor_stop_o |-> !speed_limit_en_o;
    endproperty
    a_lim_stop: assert property (p_lim_stop)
        else $error("speed limit while stopped");
    property p_dev_alm;
        mode_reg == 2'h0 && !motor_stop_o && !speed_limit_en_o && over
        && servo_on_pin_i && !limit_sw_pin_i |=> ##[0:1] alarm_o;
    endproperty
    a_dev_alm: assert property (p_dev_alm)
        else $error("no alarm on deviation overflow");
endmodule : pdg_props
bind pdg_guard pdg_props u_props (.*);

// ---- dv/pdg_host.sv ----
// Purpose: host side model giving references and servo on
// Assumes: one reference strobe per call
// Notes:   signals change just after a rising edge
`include "pdg_cfg.svh"
module pdg_host (
    // clock
    input  wire logic                    clk_i,
    // towards the guard
    output logic signed [`PDG_POS_W-1:0] ref_pos_o,
    output logic                         ref_valid_o,
    output logic                         servo_on_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {ref_pos_o, ref_valid_o, servo_on_o} = '0;
    task automatic send(input logic signed [`PDG_POS_W-1:0] p);
        @(posedge clk_i);
        ref_pos_o <= p;
        ref_valid_o <= 1'b1;
        @(posedge clk_i);
        ref_valid_o <= 1'b0;
    endtask : send
    task automatic servo(input logic on);
        @(posedge clk_i);
        servo_on_o <= on;
    endtask : servo
endmodule : pdg_host

// ---- dv/test_pdg_guard.sv ----
// Purpose: register level tests of the deviation guard
// Assumes: host model drives reference and servo on
// Notes:   none
`include "pdg_cfg.svh"
module test_pdg_guard;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk = 1'b0;
    logic               arst_n;
    logic [3:0]         addr;
    logic [31:0]        wdata;
    logic               wr;
    logic               rd;
    logic [31:0]        rdata;
    logic signed [31:0] ref_pos;
    logic               ref_vld;
    logic               son;
    logic signed [31:0] act;
    logic [15:0]        vib;
    logic signed [15:0] trq_ref;
    logic               lsw;
    logic               stop;
    logic               lim_en;
    logic [13:0]        lim;
    logic signed [15:0] trq;
    logic               alarm;
    logic               warn;
    logic               irq;
    logic [31:0]        got;
    int                 n_fail = 0;
    int                 compares = 0;
    int                 cycles = 0;
    pdg_host host (.clk_i(clk), .ref_pos_o(ref_pos), .ref_valid_o(ref_vld),
        .servo_on_o(son));
    pdg_guard dut (.clk_i(clk), .arst_n_i(arst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .ref_pos_i(ref_pos), .ref_valid_i(ref_vld),
        .act_pos_i(act), .vib_i(vib), .trq_ref_i(trq_ref),
        .servo_on_pin_i(son), .limit_sw_pin_i(lsw), .motor_stop_o(stop),
        .speed_limit_en_o(lim_en), .speed_limit_o(lim), .trq_cmd_o(trq),
        .alarm_o(alarm), .warning_o(warn), .irq_o(irq));
    ////////////////////////////////////////////////////////////////////
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask : rd_reg
    task automatic chk(input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic move(input logic [31:0] r, a);
        @(posedge clk);
        act <= a;
        host.send(r);
        repeat (3) @(posedge clk);
    endtask : move
    // servo off, alarm reset, status cleared
    task automatic calm;
        move(0, 0);
        host.servo(1'b0);
        repeat (6) @(posedge clk);
        wr_reg(4'h0, 32'h8);
        rd_reg(4'h8);
        repeat (2) @(posedge clk);
        chk(irq, 0);
    endtask : calm
    task automatic start;
        host.servo(1'b1);
        repeat (6) @(posedge clk);
    endtask : start
    task automatic summarize;
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            summarize();
        end
    end
    localparam logic [3:0] RA [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
    localparam logic [31:0] DV [5] = '{32'h500000, 32'h64, 32'h500000,
        32'h64, 32'h2710};
    localparam logic [31:0] WV [5] = '{0, 5, 0, 200, 20000};
    localparam logic [31:0] EV [5] = '{1, 32'hA, 1, 32'h64, 32'h2710};
    initial begin
        {arst_n, addr, wdata, wr, rd, act, vib, trq_ref, lsw} = '0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd_reg(RA[i]);
            chk(got, DV[i]);
            wr_reg(RA[i], WV[i]);
            rd_reg(RA[i]);
            chk(got, EV[i]);
        end
        rd_reg(4'hF);
        chk(got, 0);
        wr_reg(4'h1, 100);
        wr_reg(4'h2, 50);
        wr_reg(4'h9, 1);
        start();
        move(0, 51);
        chk({warn, irq}, 2'b10);
        rd_reg(4'hA);
        chk(got, 32'hFFFF_FFCD);
        rd_reg(4'h8);
        chk(got, 2);
        move(100, 0);
        chk(alarm, 0);
        move(101, 0);
        chk({alarm, stop, irq}, 3'b111);
        rd_reg(4'h8);
        chk(got & 1, 1);
        calm();
        wr_reg(4'h0, 32'h2);
        move(0, 500);
        start();
        chk(alarm, 0);
        calm();
        wr_reg(4'h3, 100);
        wr_reg(4'h1, 1000);
        move(0, 200);
        start();
        chk(alarm, 1);
        rd_reg(4'h8);
        chk(got, 32'hC);
        calm();
        wr_reg(4'h4, 50);
        wr_reg(4'h5, 32'h4D2);
        move(0, 60);
        start();
        chk({lim_en, lim}, {1'b1, 14'h4D2});
        rd_reg(4'h8);
        chk(got, 8);
        move(1100, 60);
        rd_reg(4'h8);
        chk({got[4], alarm}, 2'b11);
        calm();
        wr_reg(4'h7, 1000);
        start();
        trq_ref <= 2000;
        vib <= 16'h90;
        move(0, 0);
        chk(trq, 1000);
        rd_reg(4'h8);
        chk(got & 32'h60, 32'h40);
        vib <= 16'h101;
        move(0, 0);
        rd_reg(4'h8);
        chk(got & 32'h20, 32'h20);
        vib <= 0;
        calm();
        start();
        lsw <= 1'b1;
        move(0, 0);
        rd_reg(4'h8);
        chk({got[7], stop, trq}, {2'b11, 16'h0});
        summarize();
    end
endmodule : test_pdg_guard
